// *** design/ccgu_pkg.sv ***
package ccgu_pkg;
    // clock of the register side
    localparam int CLK_MHZ = 100;
    localparam int CLK_PERIOD_NS = 10;

    // register byte offsets
    localparam logic [7:0] CCGU_OFF_CTRL = 8'h00;
    localparam logic [7:0] CCGU_OFF_TRIM = 8'h04;
    localparam logic [7:0] CCGU_OFF_DIV = 8'h08;
    localparam logic [7:0] CCGU_OFF_AUX1 = 8'h0c;
    localparam logic [7:0] CCGU_OFF_STAT = 8'h10;

    // field positions
    localparam int CTRL_DONE_BIT = 7;
    localparam int CTRL_DBL_BIT = 3;
    localparam int TRIM_CLKOUT_BIT = 6;
    localparam int AUX1_LP_BIT = 7;

    // reset values before the straps are caught
    localparam logic [2:0] SRC_RST = 3'h3;
    localparam logic [5:0] TRIM_RST = 6'h20;
    localparam logic [7:0] DIV_RST = 8'h00;

    // oscillator selection codes
    localparam logic [2:0] SRC_XTAL_HI = 3'h0;
    localparam logic [2:0] SRC_XTAL_MED = 3'h1;
    localparam logic [2:0] SRC_XTAL_LOW = 3'h2;
    localparam logic [2:0] SRC_RC = 3'h3;
    localparam logic [2:0] SRC_WDOSC = 3'h4;
    localparam logic [2:0] SRC_EXT = 3'h7;

    // index of each oscillator in the input vector
    localparam logic [1:0] IDX_XTAL = 2'h0;
    localparam logic [1:0] IDX_RC = 2'h1;
    localparam logic [1:0] IDX_WDOSC = 2'h2;
    localparam logic [1:0] IDX_EXT = 2'h3;

    // nominal oscillator rates, for reference by the analog side
    localparam int RC_NOM_KHZ = 7373;
    localparam int RC_DBL_KHZ = 14746;
    localparam int WDOSC_NOM_KHZ = 400;

    // wake-up delays
    localparam logic [14:0] XTAL_WAKE_EDGES = 15'h0400;
    localparam int XTAL_EXTRA_US = 60;
    localparam int XTAL_EXTRA_CYC = (XTAL_EXTRA_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RC_MIN_US = 200;
    localparam int RC_MAX_US = 300;
    localparam int RC_WAIT_CYC = (RC_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [14:0] SHORT_WAKE_EDGES = 15'h0020;

    // new-source edges seen before a switch completes
    localparam logic [2:0] SW_SETTLE_EDGES = 3'h4;

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic awvalid;
        logic [31:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [31:0] araddr;
        logic rready;
    } ccgu_axil_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } ccgu_axil_rsp_t;
endpackage : ccgu_pkg

// *** design/ccgu_top.sv ***
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ns
// What this block does
// - machine cycle equals two cpu clock cycles
// - peripheral clock is cpu clock halved
// - root clock picked from four oscillators
// - rc oscillator nominal, doubled when enabled
// - clock out only when crystal not active root, rtc or watchdog source
// - clock out gated by enable, half cpu
// - six-bit trim, factory value, software writable
// - doubler active when its config bit set
// - low power bit resets zero, software sets
// - switch flag clears at start, sets done
// - control writes ignored during a switch
// - crystal wake waits 1024 edges plus 60us
// - rc wake waits 200 to 300 us
// - watchdog or external wake waits 32 edges
// - divider reaches divide by 510
// - divider rewrite takes effect without stopping
// - watchdog oscillator selectable as root source
// - source choice comes from stored configuration
// - crystal feeds root and rtc, low speed watchdog
// - reset loads source and doubler from config
module ccgu_top
    import ccgu_pkg::*;
#(
    parameter int XTAL_EXTRA_CYCLES = XTAL_EXTRA_CYC,
    parameter int RC_WAIT_CYCLES = RC_WAIT_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire ccgu_axil_req_t axi_req,
    output ccgu_axil_rsp_t axi_rsp,
    input wire logic [3:0] osc_in,
    input wire logic [2:0] user_config_1_src,
    input wire logic user_config_2_dbl,
    input wire logic [5:0] factory_trim,
    input wire logic rtc_uses_xtal,
    input wire logic wdt_uses_xtal,
    input wire logic wake_req,
    output logic cpu_tick_r,
    output logic periph_clk_r,
    output logic mcycle_end_r,
    output logic clkout_r,
    output logic clkout_oe_r,
    output logic rc_doubler_en_r,
    output logic [5:0] rc_trim_r,
    output logic xtal_osc_en_r,
    output logic wdt_xtal_ok_r,
    output logic low_power_clock_select_r
);

    typedef enum logic [1:0] {WK_RUN, WK_ROOT, WK_TIME} ccgu_wake_t;

    // synchroniser stages and edge history of the oscillator inputs
    logic [3:0] osc_s1_r;
    logic [3:0] osc_s2_r;
    logic [3:0] osc_s3_r;
    logic [3:0] osc_edge;
    // straps caught after reset release
    logic cfg_done_r;
    logic boot_r;
    // control register state
    logic [2:0] src_req_r;
    logic [2:0] src_act_r;
    logic switch_done_r;
    logic [2:0] sw_cnt_r;
    logic [7:0] clock_divider_value_r;
    logic clkout_enable_r;
    // clock chain state
    logic root_tick;
    logic [8:0] div_cnt_r;
    logic [8:0] div_limit;
    logic cpu_go;
    logic cpu_phase_r;
    ccgu_wake_t wake_st_r;
    logic [14:0] wake_cnt_r;
    logic clkout_allowed;
    // bus state
    logic awready_r;
    logic wready_r;
    logic aw_held_r;
    logic w_held_r;
    logic [7:0] aw_addr_r;
    logic aw_hi_ok_r; // upper address bits were zero when the address was taken
    logic [31:0] w_data_r;
    logic w_lane0_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic arready_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic wr_fire;
    logic wr_en;
    logic [31:0] rd_word;
    logic rd_hit;

    // maps a selection code onto the oscillator that serves it
    function automatic logic [1:0] src_index(input logic [2:0] code);
        logic [1:0] idx;
        idx = IDX_RC;
        case (code)
            SRC_XTAL_HI, SRC_XTAL_MED, SRC_XTAL_LOW: idx = IDX_XTAL;
            SRC_WDOSC: idx = IDX_WDOSC;
            SRC_EXT: idx = IDX_EXT;
            default: idx = IDX_RC;
        endcase
        return idx;
    endfunction : src_index

    // true for any of the three crystal speed options
    function automatic logic is_xtal(input logic [2:0] code);
        return (code == SRC_XTAL_HI) || (code == SRC_XTAL_MED) || (code == SRC_XTAL_LOW);
    endfunction : is_xtal

    // oscillators are foreign to clk: two flops, then a third for the edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_s1_r <= 4'h0;
            osc_s2_r <= 4'h0;
            osc_s3_r <= 4'h0;
        end else begin
            osc_s1_r <= osc_in;
            osc_s2_r <= osc_s1_r;
            osc_s3_r <= osc_s2_r;
        end
    end

    // rising edge of each oscillator, one pulse per period
    for (genvar g = 0; g < 4; g++) begin : g_edge
        assign osc_edge[g] = osc_s2_r[g] & ~osc_s3_r[g];
    end

    // root clock is the active source among the four oscillators
    assign root_tick = osc_edge[src_index(src_act_r)];

    // straps are sampled on the first edge after reset release
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_done_r <= 1'b0;
            boot_r <= 1'b0;
        end else begin
            cfg_done_r <= 1'b1;
            boot_r <= ~cfg_done_r;
        end
    end

    // source selection: strap at boot, then on-the-fly switches
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            src_req_r <= SRC_RST;
            src_act_r <= SRC_RST;
            switch_done_r <= 1'b1;
            sw_cnt_r <= 3'h0;
        end else if (!cfg_done_r) begin
            // configuration stored at programming picks the source
            src_req_r <= user_config_1_src;
            src_act_r <= user_config_1_src;
        end else if (!switch_done_r) begin
            // count edges of the new source before handing over
            if (osc_edge[src_index(src_req_r)]) begin
                if (sw_cnt_r == SW_SETTLE_EDGES - 3'h1) begin
                    src_act_r <= src_req_r;
                    switch_done_r <= 1'b1;
                    sw_cnt_r <= 3'h0;
                end else begin
                    sw_cnt_r <= sw_cnt_r + 3'h1;
                end
            end
        end else if (wr_en && aw_addr_r == CCGU_OFF_CTRL && w_data_r[2:0] != src_req_r) begin
            // a new source code starts a switch and drops the flag
            src_req_r <= w_data_r[2:0];
            switch_done_r <= 1'b0;
            sw_cnt_r <= 3'h0;
        end
    end

    // doubler bit: strap at boot, writable only while no switch runs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rc_doubler_en_r <= 1'b0;
        end else if (!cfg_done_r) begin
            rc_doubler_en_r <= user_config_2_dbl;
        end else if (wr_en && aw_addr_r == CCGU_OFF_CTRL && switch_done_r) begin
            // doubler drives the rc oscillator to its doubled rate
            rc_doubler_en_r <= w_data_r[CTRL_DBL_BIT];
        end
    end

    // rc trim and clock output enable
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rc_trim_r <= TRIM_RST;
            clkout_enable_r <= 1'b0;
        end else if (!cfg_done_r) begin
            // factory value loaded as reset ends
            rc_trim_r <= factory_trim;
        end else if (wr_en && aw_addr_r == CCGU_OFF_TRIM) begin
            // software retunes the oscillator afterwards
            rc_trim_r <= w_data_r[5:0];
            clkout_enable_r <= w_data_r[TRIM_CLKOUT_BIT];
        end
    end

    // divider value, rewritable at any moment
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clock_divider_value_r <= DIV_RST;
        end else if (wr_en && aw_addr_r == CCGU_OFF_DIV) begin
            clock_divider_value_r <= w_data_r[7:0];
        end
    end

    // low power select bit, cleared by every reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            low_power_clock_select_r <= 1'b0;
        end else if (wr_en && aw_addr_r == CCGU_OFF_AUX1) begin
            // software sets it only at 8 MHz or below
            low_power_clock_select_r <= w_data_r[AUX1_LP_BIT];
        end
    end

    // root edges per cpu cycle less one: 2n-1, up to 509
    assign div_limit = {clock_divider_value_r, 1'b0} - 9'h001;

    // cpu clock is held back while the wake-up timer runs
    assign cpu_go = (wake_st_r == WK_RUN);

    // divider: counts root edges, the limit is read live so a rewrite
    // only moves the next terminal count and never stalls the cpu
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt_r <= 9'h000;
            cpu_tick_r <= 1'b0;
        end else begin
            cpu_tick_r <= 1'b0;
            if (root_tick) begin
                if (clock_divider_value_r == 8'h00) begin
                    // zero passes every root edge through
                    div_cnt_r <= 9'h000;
                    cpu_tick_r <= cpu_go;
                end else if (div_cnt_r >= div_limit) begin
                    div_cnt_r <= 9'h000;
                    cpu_tick_r <= cpu_go;
                end else begin
                    div_cnt_r <= div_cnt_r + 9'h001;
                end
            end
        end
    end

    // phase of the machine cycle and the derived half-rate clocks
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cpu_phase_r <= 1'b0;
            periph_clk_r <= 1'b0;
            mcycle_end_r <= 1'b0;
        end else begin
            mcycle_end_r <= 1'b0;
            if (cpu_tick_r) begin
                // two cpu cycles make one machine cycle
                cpu_phase_r <= ~cpu_phase_r;
                mcycle_end_r <= cpu_phase_r;
                // peripherals run at half the cpu rate
                periph_clk_r <= ~cpu_phase_r;
            end
        end
    end

    // pin is free only when the active source, rtc and watchdog do not use the crystal
    assign clkout_allowed = ~is_xtal(src_act_r) & ~rtc_uses_xtal & ~wdt_uses_xtal;

    // clock output: half the cpu rate, driven only when enabled
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clkout_r <= 1'b0;
            clkout_oe_r <= 1'b0;
        end else begin
            clkout_oe_r <= clkout_allowed & clkout_enable_r;
            if (!(clkout_allowed && clkout_enable_r)) begin
                clkout_r <= 1'b0;
            end else if (cpu_tick_r) begin
                clkout_r <= ~clkout_r;
            end
        end
    end

    // crystal enable and the watchdog's right to use it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            xtal_osc_en_r <= 1'b0;
            wdt_xtal_ok_r <= 1'b0;
        end else begin
            // crystal may serve root, rtc and low-speed watchdog at once
            wdt_xtal_ok_r <= (src_req_r == SRC_XTAL_LOW);
            xtal_osc_en_r <= is_xtal(src_act_r) | is_xtal(src_req_r) | rtc_uses_xtal
                             | (wdt_uses_xtal & (src_req_r == SRC_XTAL_LOW));
        end
    end

    // wake-up timer: crystal counts root edges then a time in clk cycles, rc only the time, others only root edges
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_st_r <= WK_TIME;
            wake_cnt_r <= 15'h0000;
        end else if (boot_r || wake_req) begin
            wake_cnt_r <= 15'h0000;
            if (src_index(src_act_r) == IDX_RC) begin
                wake_st_r <= WK_TIME;
            end else begin
                wake_st_r <= WK_ROOT;
            end
        end else begin
            case (wake_st_r)
                WK_ROOT: begin
                    if (root_tick) begin
                        if (is_xtal(src_act_r) && wake_cnt_r == XTAL_WAKE_EDGES - 15'h1) begin
                            // crystal adds a fixed time after its edges
                            wake_cnt_r <= 15'h0000;
                            wake_st_r <= WK_TIME;
                        end else if (!is_xtal(src_act_r)
                                     && wake_cnt_r == SHORT_WAKE_EDGES - 15'h1) begin
                            wake_cnt_r <= 15'h0000;
                            wake_st_r <= WK_RUN;
                        end else begin
                            wake_cnt_r <= wake_cnt_r + 15'h1;
                        end
                    end
                end
                WK_TIME: begin
                    if (!cfg_done_r) begin
                        // hold until the boot sequence starts the timer
                        wake_cnt_r <= 15'h0000;
                    end else if (is_xtal(src_act_r)
                                 && wake_cnt_r >= 15'(XTAL_EXTRA_CYCLES - 1)) begin
                        wake_st_r <= WK_RUN;
                    end else if (!is_xtal(src_act_r)
                                 && wake_cnt_r >= 15'(RC_WAIT_CYCLES - 1)) begin
                        wake_st_r <= WK_RUN;
                    end else begin
                        wake_cnt_r <= wake_cnt_r + 15'h1;
                    end
                end
                WK_RUN: begin
                    wake_cnt_r <= 15'h0000;
                end
                default: begin
                    wake_st_r <= WK_RUN;
                end
            endcase
        end
    end

    // a write is performed once address and data are both held
    assign wr_fire = aw_held_r & w_held_r & ~bvalid_r;
    // an address outside the low page must leave every register alone
    assign wr_en = wr_fire & w_lane0_r & aw_hi_ok_r;

    // write address channel
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            awready_r <= 1'b0;
            aw_held_r <= 1'b0;
            aw_addr_r <= 8'h00;
            aw_hi_ok_r <= 1'b0;
        end else if (awready_r && axi_req.awvalid) begin
            awready_r <= 1'b0;
            aw_held_r <= 1'b1;
            aw_addr_r <= axi_req.awaddr[7:0];
            // master may move the address once taken, so judge it now
            aw_hi_ok_r <= (axi_req.awaddr[31:8] == 24'h0);
        end else if (wr_fire) begin
            aw_held_r <= 1'b0;
        end else if (!aw_held_r && !bvalid_r) begin
            awready_r <= 1'b1;
        end
    end

    // write data channel
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wready_r <= 1'b0;
            w_held_r <= 1'b0;
            w_data_r <= 32'h0000_0000;
            w_lane0_r <= 1'b0;
        end else if (wready_r && axi_req.wvalid) begin
            wready_r <= 1'b0;
            w_held_r <= 1'b1;
            w_data_r <= axi_req.wdata;
            w_lane0_r <= axi_req.wstrb[0];
        end else if (wr_fire) begin
            w_held_r <= 1'b0;
        end else if (!w_held_r && !bvalid_r) begin
            wready_r <= 1'b1;
        end
    end

    // write response, error for offsets outside the map
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_r <= 1'b1;
            bresp_r <= (aw_addr_r[1:0] == 2'h0 && aw_addr_r <= CCGU_OFF_STAT
                        && aw_hi_ok_r) ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_r && axi_req.bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // read decode of the register map
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit = (axi_req.araddr[31:8] == 24'h0);
        case (axi_req.araddr[7:0])
            CCGU_OFF_CTRL: begin
                rd_word[CTRL_DONE_BIT] = switch_done_r;
                rd_word[CTRL_DBL_BIT] = rc_doubler_en_r;
                rd_word[2:0] = src_req_r;
            end
            CCGU_OFF_TRIM: begin
                rd_word[TRIM_CLKOUT_BIT] = clkout_enable_r;
                rd_word[5:0] = rc_trim_r;
            end
            CCGU_OFF_DIV: rd_word[7:0] = clock_divider_value_r;
            CCGU_OFF_AUX1: rd_word[AUX1_LP_BIT] = low_power_clock_select_r;
            CCGU_OFF_STAT: begin
                rd_word[0] = ~cpu_go;
                rd_word[1] = clkout_allowed;
                rd_word[4:2] = src_act_r;
            end
            default: rd_hit = 1'b0;
        endcase
    end

    // read channel: one read at a time, data the cycle after address
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= RESP_OKAY;
        end else if (arready_r && axi_req.arvalid) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rdata_r <= rd_hit ? rd_word : 32'h0000_0000;
            rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_r && axi_req.rready) begin
            rvalid_r <= 1'b0;
        end else if (!rvalid_r && !arready_r) begin
            arready_r <= 1'b1;
        end
    end

    // responses gathered into the bus struct
    assign axi_rsp.awready = awready_r;
    assign axi_rsp.wready = wready_r;
    assign axi_rsp.bvalid = bvalid_r;
    assign axi_rsp.bresp = bresp_r;
    assign axi_rsp.arready = arready_r;
    assign axi_rsp.rvalid = rvalid_r;
    assign axi_rsp.rdata = rdata_r;
    assign axi_rsp.rresp = rresp_r;

endmodule : ccgu_top

// *** sim/ccgu_top_asserts.sv ***
`timescale 1ns/1ns
// watches the register bus and the derived clock pulses of the top
module ccgu_top_asserts
    import ccgu_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire ccgu_axil_req_t axi_req,
    input wire ccgu_axil_rsp_t axi_rsp,
    input wire logic cpu_tick_r,
    input wire logic periph_clk_r,
    input wire logic mcycle_end_r,
    input wire logic clkout_r,
    input wire logic clkout_oe_r,
    input wire logic [5:0] rc_trim_r,
    input wire logic low_power_clock_select_r
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_periph_half: assert property ($changed(periph_clk_r) |-> cpu_tick_r || $past(cpu_tick_r))
        else $error("peripheral clock moved without a cpu tick");
    a_mcycle_tick: assert property (mcycle_end_r |-> cpu_tick_r || $past(cpu_tick_r))
        else $error("machine cycle end without a cpu tick");
    a_clkout_gate: assert property (!clkout_oe_r |-> !clkout_r)
        else $error("clock out high while disabled");
    a_clkout_rate: assert property ($changed(clkout_r) && clkout_oe_r && $past(clkout_oe_r)
        |-> cpu_tick_r || $past(cpu_tick_r)) else $error("clock out moved without tick");
    a_early_tick: assert property ($rose(rst_n) |-> !cpu_tick_r [*8])
        else $error("cpu tick during wake delay");
    a_trim_write: assert property ($changed(rc_trim_r) |-> axi_rsp.bvalid || !$past(rst_n, 2))
        else $error("trim changed without a write");
    a_lp_write: assert property ($changed(low_power_clock_select_r) |-> axi_rsp.bvalid)
        else $error("low power bit changed without a write");
    a_aw_busy: assert property (axi_req.awvalid && axi_rsp.awready |=> !axi_rsp.awready [*2])
        else $error("write address accepted twice");
    a_b_done: assert property (axi_rsp.bvalid && axi_req.bready |=> !axi_rsp.bvalid)
        else $error("write response held after handshake");
    a_r_done: assert property (axi_rsp.rvalid && axi_req.rready |=> !axi_rsp.rvalid)
        else $error("read response held after handshake");
endmodule : ccgu_top_asserts

// *** sim/ccgu_osc_model.sv ***
`timescale 1ns/1ns
// four free running oscillators, half periods of 2, 3, 4 and 5 clocks
module ccgu_osc_model
    import ccgu_pkg::*;
(
    input wire logic clk,
    output logic [3:0] osc
);
    int cnt [4]; // per-oscillator half period counters
    initial begin
        osc = 4'h0;
        cnt = '{0, 0, 0, 0};
    end
    // crystal, rc, watchdog oscillator and external input each run free
    always @(posedge clk) begin
        for (int i = 0; i < 4; i++) begin
            if (cnt[i] == i + 1) begin
                cnt[i] <= 0;
                osc[i] <= ~osc[i];
            end else begin
                cnt[i] <= cnt[i] + 1;
            end
        end
    end
endmodule : ccgu_osc_model

// *** sim/cpu_clock_generation_unit_tb.sv ***
`timescale 1ns/1ns
module cpu_clock_generation_unit_tb
    import ccgu_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    ccgu_axil_req_t req = '0; // bus master side
    ccgu_axil_rsp_t rsp;
    logic [3:0] osc;
    logic rtc_x = 1'b0; // rtc borrows the crystal
    logic wdt_x = 1'b0; // watchdog borrows the crystal
    logic xen, wok;
    logic wake = 1'b0;
    logic tick, oe, lp, dbl;
    logic [5:0] trim;
    logic [31:0] d;
    logic [1:0] r;
    int n_fail = 0;
    int n_tests = 0;
    always #5 clk = ~clk;
    // doubler strapped on, rc oscillator strapped as the source
    ccgu_top #(.XTAL_EXTRA_CYCLES(20), .RC_WAIT_CYCLES(30)) i_ccgu_top (
        .clk(clk), .rst_n(rst_n), .axi_req(req), .axi_rsp(rsp), .osc_in(osc),
        .user_config_1_src(3'h3), .user_config_2_dbl(1'b1), .factory_trim(6'h2a),
        .rtc_uses_xtal(rtc_x), .wdt_uses_xtal(wdt_x), .wake_req(wake), .cpu_tick_r(tick),
        .periph_clk_r(), .mcycle_end_r(), .clkout_r(), .clkout_oe_r(oe),
        .rc_doubler_en_r(dbl), .rc_trim_r(trim), .xtal_osc_en_r(xen), .wdt_xtal_ok_r(wok),
        .low_power_clock_select_r(lp));
    ccgu_osc_model i_ccgu_osc_model (.clk(clk), .osc(osc));
    task chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            n_fail++;
            $display("[FAIL] t=%0t seen %h exp %h", $time, s, e);
        end
    endtask : chk
    // one write, address and data released as each is taken
    task wr(input logic [7:0] a, input logic [31:0] v);
        logic ta, tw;
        ta = 1'b0;
        tw = 1'b0;
        @(posedge clk);
        req.awaddr <= {24'h0, a};
        req.wdata <= v;
        req.wstrb <= 4'hf;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        do begin
            @(posedge clk);
            ta = ta | rsp.awready;
            tw = tw | rsp.wready;
            if (ta) req.awvalid <= 1'b0;
            if (tw) req.wvalid <= 1'b0;
        end while (!(ta && tw));
        do @(posedge clk); while (rsp.bvalid !== 1'b1);
        req.bready <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a);
        @(posedge clk);
        req.araddr <= {24'h0, a};
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        do @(posedge clk); while (rsp.arready !== 1'b1);
        req.arvalid <= 1'b0;
        do @(posedge clk); while (rsp.rvalid !== 1'b1);
        d = rsp.rdata;
        r = rsp.rresp;
        req.rready <= 1'b0;
    endtask : rd
    // clocks between two successive cpu ticks
    task gap(output int n);
        n = 0;
        do @(posedge clk); while (tick !== 1'b1);
        do begin
            @(posedge clk);
            n++;
        end while (tick !== 1'b1);
    endtask : gap
    task t_boot;
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (tick !== 1'b1);
        chk(n >= 33 && n <= 50, 1);
        rd(CCGU_OFF_CTRL);
        chk(d, 32'h8b);
        chk(dbl, 1'b1);
        chk(trim, 6'h2a);
        chk(lp, 1'b0);
    endtask : t_boot
    task div(input logic [7:0] v, input int e);
        int n;
        wr(CCGU_OFF_DIV, {24'h0, v});
        gap(n);
        gap(n);
        chk(n, e);
    endtask : div
    task t_div;
        div(8'h00, 6);
        div(8'h03, 36);
        div(8'hff, 3060);
        div(8'h00, 6);
    endtask : t_div
    task t_clkout;
        wr(CCGU_OFF_TRIM, 32'h55);
        repeat (4) @(posedge clk);
        chk(trim, 6'h15);
        chk(oe, 1'b1);
        chk(xen, 1'b0);
        rtc_x <= 1'b1;
        repeat (4) @(posedge clk);
        chk(oe, 1'b0);
        chk(xen, 1'b1);
        rtc_x <= 1'b0;
        wdt_x <= 1'b1;
        repeat (4) @(posedge clk);
        chk(oe, 1'b0);
        chk(xen, 1'b0);
        chk(wok, 1'b0);
        wdt_x <= 1'b0;
        wr(CCGU_OFF_TRIM, 32'h15);
        repeat (4) @(posedge clk);
        chk(oe, 1'b0);
    endtask : t_clkout
    task t_misc;
        rd(8'h14);
        chk(r, RESP_SLVERR);
        chk(d, 32'h0);
        wr(CCGU_OFF_AUX1, 32'h80);
        chk(lp, 1'b1);
    endtask : t_misc
    task t_switch;
        int n;
        wr(CCGU_OFF_CTRL, 32'h0c);
        rd(CCGU_OFF_CTRL);
        chk(d[7], 1'b0);
        wr(CCGU_OFF_CTRL, 32'h0f);
        repeat (100) @(posedge clk);
        rd(CCGU_OFF_CTRL);
        chk(d, 32'h8c);
        rd(CCGU_OFF_STAT);
        chk(d[4:2], 3'h4);
        gap(n);
        gap(n);
        chk(n, 8);
    endtask : t_switch
    // select a source, line up on a cpu tick, then time one wake-up
    task t_wake(input logic [2:0] s, input int lo, input int hi);
        int n;
        n = 0;
        wr(CCGU_OFF_CTRL, {28'h0, 1'b1, s});
        repeat (50) @(posedge clk);
        do @(posedge clk); while (tick !== 1'b1);
        wake <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
        do begin
            @(posedge clk);
            n++;
        end while (tick !== 1'b1);
        chk(n >= lo && n <= hi, 1);
        chk(wok, s == SRC_XTAL_LOW);
        chk(xen, s == SRC_XTAL_LOW);
    endtask : t_wake
    task conclude;
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : conclude
    // main sequence
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_boot();
        t_div();
        t_clkout();
        t_misc();
        t_switch();
        t_wake(3'h4, 248, 275);
        t_wake(3'h2, 4112, 4124);
        conclude();
    end
    // watchdog against a hang
    initial begin
        #500000;
        n_fail++;
        conclude();
    end
endmodule : cpu_clock_generation_unit_tb
bind ccgu_top ccgu_top_asserts i_ccgu_top_asserts (.clk(clk), .rst_n(rst_n),
    .axi_req(axi_req), .axi_rsp(axi_rsp), .cpu_tick_r(cpu_tick_r), .periph_clk_r(periph_clk_r),
    .mcycle_end_r(mcycle_end_r), .clkout_r(clkout_r), .clkout_oe_r(clkout_oe_r),
    .rc_trim_r(rc_trim_r), .low_power_clock_select_r(low_power_clock_select_r));
